// >>> wpqs_fifo.sv
// parameterised valid/ready fifo for queued writes
`timescale 1ns/1ps
`default_nettype none
module wpqs_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // pointer wrap relies on a power-of-two depth
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_depth_chk
        $error("fifo depth must be a power of two and width at least one");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    logic             push;
    logic             pop;

    assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign out_valid = wp_r != rp_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rp_r[AW-1:0]];

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            wp_r <= '0;
        else if (push)
            wp_r <= wp_r + 1'b1;
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            rp_r <= '0;
        else if (pop)
            rp_r <= rp_r + 1'b1;
    end
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wp_r[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// >>> wpqs_pkg.sv
// package for the write-port queue select block
package wpqs_pkg;
    localparam int          WPQS_ADDR_W     = 8;
    localparam int          WPQS_DEV_LSB    = 5;
    localparam int          WPQS_DEV_W      = 3;
    localparam int          WPQS_QUEUE_W    = 5;
    localparam int          WPQS_QUAD_W     = 2;
    localparam int          WPQS_DATA_W     = 18;
    localparam int          WPQS_FIFO_DEPTH = 16;
    localparam logic [4:0]  WPQS_QUEUE_RST  = 5'h00;
    localparam logic [1:0]  WPQS_QUAD_RST   = 2'h0;
    localparam logic [2:0]  WPQS_DEV_ID_DEF = 3'h0;

    typedef struct packed {
        logic [WPQS_QUEUE_W-1:0] queue;
        logic [WPQS_DATA_W-1:0]  data;
    } wpqs_word_t;
endpackage

// >>> wpqs_top.sv
// write-port queue and flag quadrant selection
// Operation
// - upper three address bits pick device; queue selection taken only on own identity match
// - queue address taken on clock edge while queue-select strobe high
// - selection edge and next edge still write the previous queue
// - second edge after selection writes the new queue
// - flag strobe picks partial-full quadrant from two lowest bits
// - quadrant selection also gated by upper three device bits
// - middle three bits ignored for quadrant selection
// - quadrant taken while flag strobe high; previous-queue write allowed
// - five lowest bits pick one of thirty-two queues
// - data stored only when active-low write enable asserted
`timescale 1ns/1ps
`default_nettype none
module wpqs_top
    import wpqs_pkg::*;
#(
    parameter logic [2:0] DEV_ID = WPQS_DEV_ID_DEF  // arbitrary value
) (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire logic [WPQS_ADDR_W-1:0]  write_select_bus,
    input  wire logic                    queue_select_strobe,
    input  wire logic                    flag_quadrant_strobe,
    input  wire logic                    write_en_n,
    input  wire logic [WPQS_DATA_W-1:0]  data_in,
    output logic                         wr_valid,
    input  wire logic                    wr_ready,
    output var wpqs_word_t               wr_word,
    output logic                         in_ready,
    output logic [WPQS_QUEUE_W-1:0]      active_queue,
    output logic [WPQS_QUAD_W-1:0]       flag_quadrant
);
    localparam int WW = $bits(wpqs_word_t);

    // pins pass two flops before use
    logic [WPQS_ADDR_W-1:0] addr_s1_r, addr_r;
    logic [1:0]             qs_s_r, fs_s_r, wen_s_r;
    logic [WPQS_DATA_W-1:0] din_s1_r, din_r;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_s1_r <= '0;
            addr_r    <= '0;
            qs_s_r    <= '0;
            fs_s_r    <= '0;
            // enable resets inactive so release brings no phantom write
            wen_s_r   <= 2'h3;
        end
        else
        begin
            addr_s1_r <= write_select_bus;
            addr_r    <= addr_s1_r;
            qs_s_r    <= {qs_s_r[0], queue_select_strobe};
            fs_s_r    <= {fs_s_r[0], flag_quadrant_strobe};
            wen_s_r   <= {wen_s_r[0], write_en_n};
        end
    end

    // data rides the same two-flop delay as the enable
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            din_s1_r <= '0;
            din_r    <= '0;
        end
        else
        begin
            din_s1_r <= data_in;
            din_r    <= din_s1_r;
        end
    end

    function automatic logic dev_match(input logic [WPQS_ADDR_W-1:0] a);
        dev_match = a[WPQS_DEV_LSB +: WPQS_DEV_W] == DEV_ID;
    endfunction
    function automatic logic [WPQS_QUEUE_W-1:0] queue_of(input logic [WPQS_ADDR_W-1:0] a);
        queue_of = a[WPQS_QUEUE_W-1:0];
    endfunction
    function automatic logic [WPQS_QUAD_W-1:0] quad_of(input logic [WPQS_ADDR_W-1:0] a);
        quad_of = a[WPQS_QUAD_W-1:0];
    endfunction

    // select bus fields must tile the bus; quadrant sits inside the queue field
    if (WPQS_DEV_LSB + WPQS_DEV_W != WPQS_ADDR_W || WPQS_QUEUE_W > WPQS_DEV_LSB
        || WPQS_QUAD_W > WPQS_QUEUE_W)
    begin : g_field_chk
        $error("select bus fields do not fit the bus");
    end

    logic qsel;
    logic fsel;
    logic wr_req;
    assign qsel   = qs_s_r[1] && dev_match(addr_r);
    assign fsel   = fs_s_r[1] && dev_match(addr_r);
    assign wr_req = !wen_s_r[1];

    // pending target sits one edge before taking over
    logic [WPQS_QUEUE_W-1:0] pend_queue_r;
    logic                    pend_r;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pend_r <= 1'b0;
        else
            pend_r <= qsel;
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            pend_queue_r <= WPQS_QUEUE_RST;
        else if (qsel)
            pend_queue_r <= queue_of(addr_r);
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            active_queue <= WPQS_QUEUE_RST;
        else if (pend_r)
            active_queue <= pend_queue_r;
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            flag_quadrant <= WPQS_QUAD_RST;
        else if (fsel)
            flag_quadrant <= quad_of(addr_r);
    end

    // writes tagged with the queue live on this edge; full fifo drops the write
    wpqs_word_t fifo_in;
    logic       fifo_ready;
    logic [WW-1:0] fifo_out;
    assign fifo_in  = '{queue: active_queue, data: din_r};
    assign in_ready = fifo_ready;
    assign wr_word  = wpqs_word_t'(fifo_out);

    wpqs_fifo #(.WIDTH(WW), .DEPTH(WPQS_FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .in_valid  (wr_req),
        .in_ready  (fifo_ready),
        .in_data   (fifo_in),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (fifo_out)
    );

    // checks on the selection pipeline
    sequence s_qsel;
        qsel ##1 !qsel;
    endsequence
    sequence s_qsel_pair;
        qsel ##1 qsel;
    endsequence
    sequence s_push;
        !wen_s_r[1] && in_ready;
    endsequence

    a_queue_takeover: assert property (@(posedge core_clk) disable iff (!nrst)
        s_qsel |=> active_queue == $past(addr_r[WPQS_QUEUE_W-1:0], 2))
        else $error("queue not switched two edges after selection");
    a_queue_prev_kept: assert property (@(posedge core_clk) disable iff (!nrst)
        qsel && !pend_r |=> active_queue == $past(active_queue))
        else $error("queue switched too early");
    a_queue_capture: assert property (@(posedge core_clk) disable iff (!nrst)
        qsel |=> pend_r && pend_queue_r == queue_of($past(addr_r)))
        else $error("queue address not captured");
    a_queue_last_wins: assert property (@(posedge core_clk) disable iff (!nrst)
        s_qsel_pair |=> ##1 active_queue == queue_of($past(addr_r, 2)))
        else $error("back to back selection lost");
    a_queue_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !qsel && !pend_r |=> $stable(active_queue))
        else $error("queue changed without selection");
    a_quad_take: assert property (@(posedge core_clk) disable iff (!nrst)
        fsel |=> flag_quadrant == $past(addr_r[1:0]))
        else $error("quadrant not captured");
    a_quad_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !fsel |=> $stable(flag_quadrant))
        else $error("quadrant changed without strobe");
    a_quad_mid_ignore: assert property (@(posedge core_clk) disable iff (!nrst)
        fsel && addr_r[4:2] != 3'h0 |=> flag_quadrant == quad_of($past(addr_r)))
        else $error("quadrant depends on middle bits");
    a_quad_strobe_only: assert property (@(posedge core_clk) disable iff (!nrst)
        !fs_s_r[1] |=> $stable(flag_quadrant))
        else $error("quadrant taken without strobe");
    a_dev_gate: assert property (@(posedge core_clk) disable iff (!nrst)
        qs_s_r[1] && !dev_match(addr_r) |=> !pend_r && $stable(pend_queue_r))
        else $error("selection taken for another device");
    a_quad_dev_gate: assert property (@(posedge core_clk) disable iff (!nrst)
        fs_s_r[1] && !dev_match(addr_r) |=> $stable(flag_quadrant))
        else $error("quadrant taken for another device");
    a_strobe_only: assert property (@(posedge core_clk) disable iff (!nrst)
        !qs_s_r[1] |=> ##1 $stable(active_queue))
        else $error("queue taken without strobe");
    a_strobes_apart: assert property (@(posedge core_clk) disable iff (!nrst)
        !(qs_s_r[1] && fs_s_r[1]))
        else $error("both strobes seen in one cycle");

    // checks on the write path; a full buffer drops writes rather than stalling
    a_write_gate: assert property (@(posedge core_clk) disable iff (!nrst)
        wen_s_r[1] |=> $stable(u_fifo.wp_r))
        else $error("write stored while disabled");
    a_write_push: assert property (@(posedge core_clk) disable iff (!nrst)
        s_push |=> u_fifo.wp_r != $past(u_fifo.wp_r))
        else $error("enabled write not stored");
    a_write_drop: assert property (@(posedge core_clk) disable iff (!nrst)
        !wen_s_r[1] && !in_ready |=> $stable(u_fifo.wp_r))
        else $error("write stored into full buffer");
    a_word_visible: assert property (@(posedge core_clk) disable iff (!nrst)
        s_push && !wr_valid |=> wr_valid)
        else $error("stored write not offered downstream");
endmodule
`default_nettype wire

// >>> wpqs_writer.sv
// writer model driving the select bus, strobes and write data
`timescale 1ns/1ps
`default_nettype none
module wpqs_writer (
    input  wire logic   core_clk,
    output logic [7:0]  wsel,
    output logic        qstb,
    output logic        fstb,
    output logic        wen_n,
    output logic [17:0] wdat
);
    initial
    begin
        wsel = 8'h00;
        qstb = 1'b0;
        fstb = 1'b0;
        wen_n = 1'b1;
        wdat = 18'h00000;
    end
    // one pin step per clock; released lines show the inverse, not a stale value
    task step(input logic q, input logic f, input logic w, input logic [7:0] a,
              input logic [17:0] d);
        @(posedge core_clk);
        qstb  <= q;
        fstb  <= f & ~q;
        wsel  <= (q | f) ? a : ~a;
        wen_n <= ~w;
        wdat  <= w ? d : ~d;
    endtask
    // no configuration pins move after reset
endmodule
`default_nettype wire

// >>> write_port_queue_select_test.sv
// testbench for the write-port queue select block
`timescale 1ns/1ps
`default_nettype none
module write_port_queue_select_test;
    import wpqs_pkg::*;
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
    localparam logic [2:0] DEV = 3'h5; // arbitrary value
    logic                   core_clk = 1'b0;
    logic                   nrst     = 1'b0;
    logic                   wr_ready = 1'b1;
    logic [7:0]             wsel;
    logic                   qstb;
    logic                   fstb;
    logic                   wen_n;
    logic [17:0]            wdat;
    logic                   wr_valid;
    wpqs_word_t             wr_word;
    logic                   in_ready;
    logic [4:0]             active_queue;
    logic [1:0]             flag_quadrant;
    wpqs_word_t             got[$];
    int                     err_count = 0;
    int                     compares  = 0;
    always #25 core_clk = ~core_clk;
    wpqs_writer u_wr (.core_clk(core_clk), .wsel(wsel), .qstb(qstb), .fstb(fstb),
        .wen_n(wen_n), .wdat(wdat));
    wpqs_top #(.DEV_ID(DEV)) i_dut (.core_clk(core_clk), .nrst(nrst),
        .write_select_bus(wsel), .queue_select_strobe(qstb),
        .flag_quadrant_strobe(fstb), .write_en_n(wen_n), .data_in(wdat),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
        .in_ready(in_ready), .active_queue(active_queue), .flag_quadrant(flag_quadrant));
    always @(posedge core_clk)
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            got.push_back(wr_word);
    task pop_chk(input logic [4:0] q, input logic [17:0] d);
        wpqs_word_t w;
        w = (got.size() > 0) ? got.pop_front() : '1;
        `CHK("word", {q, d}, w)
    endtask
    task idle(input int n);
        u_wr.step(1'b0, 1'b0, 1'b0, 8'h00, 18'h00000);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task t_reset;
        `CHK("queue", 5'h00, active_queue)
        `CHK("quad", 2'h0, flag_quadrant)
        `CHK("ready", 1'b1, in_ready)
    endtask
    // writes on the selection edge and the next still go to the old queue
    task t_switch;
        u_wr.step(1'b1, 1'b0, 1'b1, {DEV, 5'h1F}, 18'h2AAAA);
        u_wr.step(1'b0, 1'b0, 1'b1, 8'h00, 18'h15555);
        u_wr.step(1'b0, 1'b0, 1'b1, 8'h00, 18'h3C3C3);
        idle(8);
        `CHK("queue", 5'h1F, active_queue)
        pop_chk(5'h00, 18'h2AAAA);
        pop_chk(5'h00, 18'h15555);
        pop_chk(5'h1F, 18'h3C3C3);
        `CHK("count", 0, got.size())
        u_wr.step(1'b1, 1'b0, 1'b0, {DEV, 5'h0A}, 18'h00000);
        u_wr.step(1'b1, 1'b0, 1'b0, {DEV, 5'h1F}, 18'h00000);
        u_wr.step(1'b0, 1'b0, 1'b1, 8'h00, 18'h0F0F0);
        idle(8);
        `CHK("queue", 5'h1F, active_queue)
        pop_chk(5'h0A, 18'h0F0F0);
        u_wr.step(1'b1, 1'b0, 1'b0, {3'h2, 5'h03}, 18'h00000);
        idle(8);
        `CHK("queue", 5'h1F, active_queue)
    endtask
    // every quadrant with the middle bits set, a write on the strobe edge
    task t_quad;
        for (int i = 0; i < 4; i++)
        begin
            u_wr.step(1'b0, 1'b1, i == 0, {DEV, 3'h7, 2'(i)}, 18'h01234);
            idle(6);
            `CHK("quad", 2'(i), flag_quadrant)
        end
        pop_chk(5'h1F, 18'h01234);
        u_wr.step(1'b0, 1'b1, 1'b0, {3'h2, 3'h0, 2'h1}, 18'h00000);
        idle(6);
        `CHK("quad", 2'h3, flag_quadrant)
        `CHK("queue", 5'h1F, active_queue)
    endtask
    // fill past capacity while the far side stalls, then drain
    task t_fill;
        @(posedge core_clk) wr_ready <= 1'b0;
        for (int i = 0; i < 20; i++)
            u_wr.step(1'b0, 1'b0, 1'b1, 8'h00, 18'(i));
        idle(6);
        `CHK("full", 1'b0, in_ready)
        @(posedge core_clk) wr_ready <= 1'b1;
        idle(30);
        `CHK("drained", 16, got.size())
        `CHK("empty", 1'b0, wr_valid)
        pop_chk(5'h1F, 18'h00000);
    endtask
    task results;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        idle(4); // no serial setup here, so selections start after reset
        t_reset();
        t_switch();
        t_quad();
        t_fill();
        results();
    end
    initial
    begin
        repeat (2000) @(posedge core_clk);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
